/* File: src/cyclic_status_variable_port.v */
// cyclic process data image with status mirror and variable channel
`timescale 1ns/1ps
`include "cyclic_port_consts.vh"
module cyclic_status_variable_port #(
    parameter W = 16
) (
    input wire I_CLK_SYS,
    input wire I_ARST_N,
    // cycle strobe from the fieldbus side
    input wire I_CYCLE_STB,
    // host-to-device words 0,1,4..7
    input wire [W-1:0] I_OUT_WORD0,
    input wire [W-1:0] I_OUT_WORD1,
    input wire [W-1:0] I_OUT_WORD4,
    input wire [W-1:0] I_OUT_WORD5,
    input wire [W-1:0] I_OUT_WORD6,
    input wire [W-1:0] I_OUT_WORD7,
    // machine status
    input wire I_TUNE_GOOD,
    input wire I_INT_CAL_GOOD,
    input wire I_FILAMENT_ACTIVE,
    input wire I_FILAMENT1_OK,
    input wire I_FILAMENT2_OK,
    input wire I_READY,
    input wire I_BUSY,
    input wire [3:0] I_LIMIT_HIT,
    input wire I_EXT_CAL_GOOD,
    input wire [W-1:0] I_ACTION_STATE,
    input wire [W-1:0] I_RATE_MANT,
    input wire [W-1:0] I_RATE_EXP,
    // device-to-host words
    output reg [W-1:0] O_IN_WORD0,
    output reg [W-1:0] O_IN_WORD1,
    output reg [W-1:0] O_IN_WORD2,
    output reg [W-1:0] O_IN_WORD3,
    output reg [W-1:0] O_IN_WORD4,
    output reg [W-1:0] O_IN_WORD5,
    output reg [W-1:0] O_IN_WORD6,
    output reg [W-1:0] O_IN_WORD7,
    // action pulses and levels to the instrument
    output reg O_START_INT_CAL,
    output reg O_START_ZERO,
    output reg O_START_OFFSET,
    output reg O_START_TUNE,
    output reg O_START_EXT_CAL,
    output reg O_READ_STD_LEAK,
    output reg O_PARALLEL_EN,
    output reg O_MANUAL_RANGE,
    output reg [W-1:0] O_ACTION_REQ,
    // variable contents to the instrument
    output wire O_PANEL_LOCKOUT,
    output wire [W-1:0] O_DATE_MONTH,
    output wire [W-1:0] O_DATE_DAY,
    output wire [W-1:0] O_DATE_YEAR,
    output reg O_DATE_LOAD,
    output wire O_DISPLAY_LOG,
    output wire [W-1:0] O_EXPONENT,
    output wire [W-1:0] O_LEAK_MANT,
    output wire [W-1:0] O_LEAK_EXP,
    output wire O_LEAK_EXP_POS,
    output wire [W-1:0] O_GAIN
);
    // ****************************************
    // variable storage
    // ****************************************
    reg [W-1:0] panel_lockout_var_r;
    reg [W-1:0] date_r [0:2];
    reg [W-1:0] display_r;
    reg [W-1:0] exponent_r;
    reg [W-1:0] leak_r [0:2];
    reg [W-1:0] gain_r;
    reg busy_cmd_r;
    wire [4:0] rise;
    wire [7:0] cmd_idx;
    wire [7:0] cmd_code;
    wire cmd_clear;
    reg idx_ok;
    reg [W-1:0] rd0;
    reg [W-1:0] rd1;
    reg [W-1:0] rd2;

    assign cmd_idx = I_OUT_WORD4[7:0];
    assign cmd_code = I_OUT_WORD4[15:8];
    assign cmd_clear = (I_OUT_WORD4 == {W{1'b0}});

    assign O_PANEL_LOCKOUT = panel_lockout_var_r[0];
    assign O_DATE_MONTH = date_r[0];
    assign O_DATE_DAY = date_r[1];
    assign O_DATE_YEAR = date_r[2];
    assign O_DISPLAY_LOG = display_r[0];
    assign O_EXPONENT = exponent_r;
    assign O_LEAK_MANT = leak_r[0];
    assign O_LEAK_EXP = leak_r[1];
    assign O_LEAK_EXP_POS = leak_r[2][0];
    assign O_GAIN = gain_r;

    // ****************************************
    // parallel request edges, levels and action request
    // ****************************************
    edge_pulse_bank #(
        .WIDTH(`PAR_EDGE_W)
    ) u_edges (
        .I_CLK_SYS(I_CLK_SYS),
        .I_ARST_N(I_ARST_N),
        .i_sample_en(I_CYCLE_STB),
        .i_level(I_OUT_WORD0[`PAR_EDGE_LSB+`PAR_EDGE_W-1:`PAR_EDGE_LSB]),
        .o_rise(rise)
    );

    always @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_START_INT_CAL <= 1'b0;
            O_START_ZERO <= 1'b0;
            O_START_OFFSET <= 1'b0;
            O_START_TUNE <= 1'b0;
            O_START_EXT_CAL <= 1'b0;
            O_READ_STD_LEAK <= 1'b0;
            O_PARALLEL_EN <= 1'b0;
            O_MANUAL_RANGE <= 1'b0;
            O_ACTION_REQ <= {W{1'b0}};
        end else begin
            O_START_INT_CAL <= rise[0];
            O_START_ZERO <= rise[1];
            O_START_OFFSET <= rise[2];
            O_START_TUNE <= rise[3];
            O_START_EXT_CAL <= rise[4];
            if (I_CYCLE_STB) begin
                O_READ_STD_LEAK <= I_OUT_WORD0[`PAR_STD_LEAK];
                O_PARALLEL_EN <= I_OUT_WORD0[`PAR_ENABLE];
                O_MANUAL_RANGE <= I_OUT_WORD0[`PAR_MANUAL];
                O_ACTION_REQ <= I_OUT_WORD1 & `ACTION_MASK;
            end
        end
    end

    // ****************************************
    // status mirror words
    // ****************************************
    always @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_IN_WORD0 <= {W{1'b0}};
            O_IN_WORD1 <= {W{1'b0}};
            O_IN_WORD2 <= {W{1'b0}};
            O_IN_WORD3 <= {W{1'b0}};
        end else if (I_CYCLE_STB) begin
            O_IN_WORD0 <= {4'h0, I_EXT_CAL_GOOD, I_LIMIT_HIT, I_BUSY, I_READY,
                           I_FILAMENT2_OK, I_FILAMENT1_OK, I_FILAMENT_ACTIVE,
                           I_INT_CAL_GOOD, I_TUNE_GOOD};
            O_IN_WORD1 <= I_ACTION_STATE & `STATE_MASK;
            O_IN_WORD2 <= I_RATE_MANT;
            O_IN_WORD3 <= I_RATE_EXP;
        end
    end

    // ****************************************
    // variable read decode
    // ****************************************
    always @* begin
        idx_ok = 1'b1;
        rd0 = {W{1'b0}};
        rd1 = {W{1'b0}};
        rd2 = {W{1'b0}};
        case (cmd_idx)
            `IDX_PANEL_LOCKOUT: begin
                rd0 = panel_lockout_var_r;
            end
            `IDX_CURRENT_DATE: begin
                rd0 = date_r[0];
                rd1 = date_r[1];
                rd2 = date_r[2];
            end
            `IDX_DISPLAY: begin
                rd0 = display_r;
            end
            `IDX_EXPONENT: begin
                rd0 = exponent_r;
            end
            `IDX_OUTSIDE_LEAK: begin
                rd0 = leak_r[0];
                rd1 = leak_r[1];
                rd2 = leak_r[2];
            end
            `IDX_GAIN: begin
                rd0 = gain_r;
            end
            default: begin
                idx_ok = 1'b0;
            end
        endcase
    end

    // ****************************************
    // variable command channel
    // ****************************************
    always @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_IN_WORD4 <= {W{1'b0}};
            O_IN_WORD5 <= {W{1'b0}};
            O_IN_WORD6 <= {W{1'b0}};
            O_IN_WORD7 <= {W{1'b0}};
            busy_cmd_r <= 1'b0;
            O_DATE_LOAD <= 1'b0;
            panel_lockout_var_r <= `RST_PANEL_LOCKOUT;
            date_r[0] <= `RST_DATE_MONTH;
            date_r[1] <= `RST_DATE_DAY;
            date_r[2] <= `RST_DATE_YEAR;
            display_r <= `RST_DISPLAY;
            exponent_r <= `RST_EXPONENT;
            leak_r[0] <= `RST_LEAK_MANT;
            leak_r[1] <= `RST_LEAK_EXP;
            leak_r[2] <= `RST_LEAK_SIGN;
            gain_r <= `RST_GAIN;
        end else begin
            O_DATE_LOAD <= 1'b0;
            if (I_CYCLE_STB) begin
                if (cmd_clear) begin
                    O_IN_WORD4 <= {W{1'b0}};
                    busy_cmd_r <= 1'b0;
                end else if (!busy_cmd_r) begin
                    busy_cmd_r <= 1'b1;
                    if (!idx_ok) begin
                        O_IN_WORD4 <= {`STATUS_ERR, `ERR_BAD_INDEX};
                    end else if (cmd_code == `CMD_WRITE) begin
                        O_IN_WORD4 <= I_OUT_WORD4;
                        O_IN_WORD5 <= I_OUT_WORD5;
                        O_IN_WORD6 <= I_OUT_WORD6;
                        O_IN_WORD7 <= I_OUT_WORD7;
                        case (cmd_idx)
                            `IDX_PANEL_LOCKOUT: begin
                                panel_lockout_var_r <= I_OUT_WORD5;
                            end
                            `IDX_CURRENT_DATE: begin
                                date_r[0] <= I_OUT_WORD5;
                                date_r[1] <= I_OUT_WORD6;
                                date_r[2] <= I_OUT_WORD7;
                                O_DATE_LOAD <= 1'b1;
                            end
                            `IDX_DISPLAY: begin
                                display_r <= I_OUT_WORD5;
                            end
                            `IDX_EXPONENT: begin
                                exponent_r <= I_OUT_WORD5;
                            end
                            `IDX_OUTSIDE_LEAK: begin
                                leak_r[0] <= I_OUT_WORD5;
                                leak_r[1] <= I_OUT_WORD6;
                                leak_r[2] <= I_OUT_WORD7;
                            end
                            `IDX_GAIN: begin
                                gain_r <= I_OUT_WORD5;
                            end
                            default: begin
                                busy_cmd_r <= 1'b1;
                            end
                        endcase
                    end else if (cmd_code == `CMD_READ) begin
                        O_IN_WORD4 <= I_OUT_WORD4;
                        O_IN_WORD5 <= rd0;
                        O_IN_WORD6 <= rd1;
                        O_IN_WORD7 <= rd2;
                    end else begin
                        O_IN_WORD4 <= {`STATUS_ERR, `ERR_BAD_CMD};
                    end
                end
            end
        end
    end
endmodule

/* File: src/cyclic_port_consts.vh */
// constants for the cyclic status and variable port
`ifndef CYCLIC_PORT_CONSTS_VH
`define CYCLIC_PORT_CONSTS_VH

`define WORD_W 16
`define IMAGE_WORDS 8

// command codes and status
`define CMD_WRITE 8'h81
`define CMD_READ 8'h82
`define STATUS_ERR 8'h7F
`define ERR_BAD_INDEX 8'h01
`define ERR_READ_ONLY 8'h02
`define ERR_BAD_CMD 8'h03

// variable indices
`define IDX_PANEL_LOCKOUT 8'h02
`define IDX_CURRENT_DATE 8'h03
`define IDX_DISPLAY 8'h04
`define IDX_EXPONENT 8'h05
`define IDX_OUTSIDE_LEAK 8'h06
`define IDX_GAIN 8'h07

// reset values of the variables
`define RST_PANEL_LOCKOUT 16'h0000
`define RST_DATE_MONTH 16'h0001
`define RST_DATE_DAY 16'h0001
`define RST_DATE_YEAR 16'h07D0
`define RST_DISPLAY 16'h0001
`define RST_EXPONENT 16'h0000
`define RST_LEAK_MANT 16'h0000
`define RST_LEAK_EXP 16'h0000
`define RST_LEAK_SIGN 16'h0000
`define RST_GAIN 16'h0016

// output word 0 field positions
`define PAR_EDGE_LSB 0
`define PAR_EDGE_W 5
`define PAR_STD_LEAK 5
`define PAR_ENABLE 6
`define PAR_MANUAL 7

// output word 1 implemented bit mask
`define ACTION_MASK 16'h7C2F

// input word 1 implemented bit mask, manual ranging included
`define STATE_MASK 16'h7D2F

`endif

/* File: src/edge_pulse_bank.v */
// rising edge detector bank for the edge-triggered request bits
`timescale 1ns/1ps
module edge_pulse_bank #(
    parameter WIDTH = 5
) (
    input wire I_CLK_SYS,
    input wire I_ARST_N,
    input wire i_sample_en,
    input wire [WIDTH-1:0] i_level,
    output wire [WIDTH-1:0] o_rise
);
    reg [WIDTH-1:0] prev_r;

    always @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            prev_r <= {WIDTH{1'b0}};
        end else if (i_sample_en) begin
            prev_r <= i_level;
        end
    end

    assign o_rise = i_sample_en ? (i_level & ~prev_r) : {WIDTH{1'b0}};
endmodule

/* File: testbench/cyclic_port_asserts.sv */
// assertions on the cyclic status and variable port
`timescale 1ns/1ps
module cyclic_port_asserts #(
    parameter W = 16
) (
    input wire I_CLK_SYS,
    input wire I_ARST_N,
    input wire I_CYCLE_STB,
    input wire [W-1:0] I_OUT_WORD0,
    input wire [W-1:0] I_OUT_WORD1,
    input wire [W-1:0] I_OUT_WORD4,
    input wire [W-1:0] I_OUT_WORD5,
    input wire I_BUSY,
    input wire [3:0] I_LIMIT_HIT,
    input wire [W-1:0] I_ACTION_STATE,
    input wire [W-1:0] I_RATE_MANT,
    input wire [W-1:0] O_IN_WORD0,
    input wire [W-1:0] O_IN_WORD1,
    input wire [W-1:0] O_IN_WORD2,
    input wire [W-1:0] O_IN_WORD4,
    input wire [W-1:0] O_IN_WORD5,
    input wire O_START_ZERO,
    input wire O_MANUAL_RANGE,
    input wire [W-1:0] O_ACTION_REQ,
    input wire [W-1:0] O_GAIN
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_ARST_N);
    // ****
    // variable channel, status mirror and parallel request checks
    // ****
    sequence s_free;
        O_IN_WORD4 == 16'h0000;
    endsequence
    sequence s_gain_wr;
        I_CYCLE_STB && I_OUT_WORD4 == 16'h8107;
    endsequence
    property p_gain;
        (s_free and s_gain_wr) |=> O_IN_WORD4 == 16'h8107 && O_GAIN == $past(I_OUT_WORD5)
            && O_IN_WORD5 == $past(I_OUT_WORD5);
    endproperty
    a_gain: assert property (p_gain) else $error("gain write not taken");
    property p_clear;
        I_CYCLE_STB && I_OUT_WORD4 == 16'h0000 |=> O_IN_WORD4 == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) else $error("status not cleared");
    property p_word0;
        I_CYCLE_STB |=> {O_IN_WORD0[15:12], O_IN_WORD0[10:6]} ==
            {4'h0, $past(I_LIMIT_HIT), $past(I_BUSY)};
    endproperty
    a_word0: assert property (p_word0) else $error("mirror word wrong");
    property p_status;
        I_CYCLE_STB |=> O_IN_WORD1 == ($past(I_ACTION_STATE) & 16'h7D2F)
            && O_IN_WORD2 == $past(I_RATE_MANT);
    endproperty
    a_status: assert property (p_status) else $error("status words wrong");
    property p_hold;
        !I_CYCLE_STB |=> $stable(O_IN_WORD1) && $stable(O_IN_WORD2);
    endproperty
    a_hold: assert property (p_hold) else $error("words moved between cycles");
    property p_rise;
        O_START_ZERO |-> $past(I_CYCLE_STB) && $past(I_OUT_WORD0[1]) ##1 !O_START_ZERO;
    endproperty
    a_rise: assert property (p_rise) else $error("zero pulse wrong");
    property p_level;
        I_CYCLE_STB |=> O_MANUAL_RANGE == $past(I_OUT_WORD0[7]);
    endproperty
    a_level: assert property (p_level) else $error("manual range level wrong");
    property p_action;
        I_CYCLE_STB |=> O_ACTION_REQ == ($past(I_OUT_WORD1) & 16'h7C2F);
    endproperty
    a_action: assert property (p_action) else $error("action request wrong");
endmodule

/* File: testbench/fieldbus_host_model.sv */
// host model: cycle strobe and variable channel handshake
`timescale 1ns/1ps
module fieldbus_host_model (
    input wire i_clk,
    output reg o_stb = 1'b0,
    output reg [15:0] o_word0 = 16'h0000,
    output reg [15:0] o_word1 = 16'h0000,
    output reg [15:0] o_word4 = 16'h0000,
    output reg [15:0] o_word5 = 16'h0000,
    output reg [15:0] o_word6 = 16'h0000,
    output reg [15:0] o_word7 = 16'h0000
);
    integer gap = 1;
    integer cnt = 0;
    // ****
    // one strobe every gap cycles
    // ****
    always @(negedge i_clk) begin
        cnt <= (cnt + 1 >= gap) ? 0 : cnt + 1;
        o_stb <= (cnt + 1 >= gap);
    end
    task cycle;
        begin
            @(posedge i_clk);
            while (!o_stb) begin
                @(posedge i_clk);
            end
            @(negedge i_clk);
        end
    endtask
    task levels(input [15:0] a, input [15:0] b);
        begin
            o_word0 <= a;
            o_word1 <= b;
            cycle;
        end
    endtask
    task command(input [15:0] c, input [47:0] d);
        begin
            {o_word5, o_word6, o_word7} <= d;
            cycle;
            o_word4 <= c;
            cycle;
        end
    endtask
    task release_cmd;
        begin
            o_word4 <= 16'h0000;
            cycle;
        end
    endtask
endmodule

/* File: testbench/tb.sv */
// self-checking bench for the cyclic status and variable port
`timescale 1ns/1ps
bind cyclic_status_variable_port cyclic_port_asserts #(.W(W)) cyclic_port_asserts_i (
    .I_CLK_SYS(I_CLK_SYS), .I_ARST_N(I_ARST_N), .I_CYCLE_STB(I_CYCLE_STB),
    .I_OUT_WORD0(I_OUT_WORD0), .I_OUT_WORD1(I_OUT_WORD1), .I_OUT_WORD4(I_OUT_WORD4),
    .I_OUT_WORD5(I_OUT_WORD5), .I_BUSY(I_BUSY), .I_LIMIT_HIT(I_LIMIT_HIT),
    .I_ACTION_STATE(I_ACTION_STATE), .I_RATE_MANT(I_RATE_MANT), .O_IN_WORD0(O_IN_WORD0),
    .O_IN_WORD1(O_IN_WORD1), .O_IN_WORD2(O_IN_WORD2), .O_IN_WORD4(O_IN_WORD4),
    .O_IN_WORD5(O_IN_WORD5), .O_START_ZERO(O_START_ZERO), .O_MANUAL_RANGE(O_MANUAL_RANGE),
    .O_ACTION_REQ(O_ACTION_REQ), .O_GAIN(O_GAIN));
module tb;
    reg clk = 1'b0;
    reg arst_n = 1'b0;
    reg [15:0] stat = 16'h0000, act = 16'h0000, mant = 16'h0000, expo = 16'h0000;
    reg [15:0] last4 = 16'h0000, p = 16'h0000, a, b;
    reg [31:0] rs = 32'h0000005F;
    reg [63:0] q[$], mq[$], e, m;
    reg [95:0] v;
    integer n_mismatch = 0, total_checks = 0, ticks = 0, nload = 0, i, k;
    wire stb, dload, lock, dlog, lpos;
    wire [15:0] hw0, hw1, hw4, hw5, hw6, hw7, w0, w1, w2, w3, w4, w5, w6, w7;
    wire [15:0] areq, mon, day, year, expv, lmant, lexp, gain;
    wire [4:0] start;
    wire [2:0] lvl;
    always #50 clk = ~clk;
    fieldbus_host_model host_i (.i_clk(clk), .o_stb(stb), .o_word0(hw0), .o_word1(hw1),
        .o_word4(hw4), .o_word5(hw5), .o_word6(hw6), .o_word7(hw7));
    cyclic_status_variable_port cyclic_status_variable_port_i (.I_CLK_SYS(clk),
        .I_ARST_N(arst_n), .I_CYCLE_STB(stb), .I_OUT_WORD0(hw0), .I_OUT_WORD1(hw1),
        .I_OUT_WORD4(hw4), .I_OUT_WORD5(hw5), .I_OUT_WORD6(hw6), .I_OUT_WORD7(hw7),
        .I_TUNE_GOOD(stat[0]), .I_INT_CAL_GOOD(stat[1]), .I_FILAMENT_ACTIVE(stat[2]),
        .I_FILAMENT1_OK(stat[3]), .I_FILAMENT2_OK(stat[4]), .I_READY(stat[5]),
        .I_BUSY(stat[6]), .I_LIMIT_HIT(stat[10:7]), .I_EXT_CAL_GOOD(stat[11]),
        .I_ACTION_STATE(act), .I_RATE_MANT(mant), .I_RATE_EXP(expo), .O_IN_WORD0(w0),
        .O_IN_WORD1(w1), .O_IN_WORD2(w2), .O_IN_WORD3(w3), .O_IN_WORD4(w4), .O_IN_WORD5(w5),
        .O_IN_WORD6(w6), .O_IN_WORD7(w7), .O_START_INT_CAL(start[0]), .O_START_ZERO(start[1]),
        .O_START_OFFSET(start[2]), .O_START_TUNE(start[3]), .O_START_EXT_CAL(start[4]),
        .O_READ_STD_LEAK(lvl[0]), .O_PARALLEL_EN(lvl[1]), .O_MANUAL_RANGE(lvl[2]),
        .O_ACTION_REQ(areq), .O_PANEL_LOCKOUT(lock), .O_DATE_MONTH(mon), .O_DATE_DAY(day),
        .O_DATE_YEAR(year), .O_DATE_LOAD(dload), .O_DISPLAY_LOG(dlog), .O_EXPONENT(expv),
        .O_LEAK_MANT(lmant), .O_LEAK_EXP(lexp), .O_LEAK_EXP_POS(lpos), .O_GAIN(gain));
    function [15:0] xs();
        begin
            rs = rs ^ (rs << 13);
            rs = rs ^ (rs >> 17);
            rs = rs ^ (rs << 5);
            xs = rs[15:0];
        end
    endfunction
    // reset value and written value of each variable
    function [95:0] tv(input integer n);
        case (n)
            2: tv = {48'h0000_0000_0000, 48'h0001_0000_0000};
            3: tv = {48'h0001_0001_07D0, 48'h000C_001F_07E8};
            4: tv = {48'h0001_0000_0000, 48'h0000_0000_0000};
            5: tv = {48'h0000_0000_0000, 48'h000A_0000_0000};
            6: tv = {48'h0000_0000_0000, 48'h00C8_0007_0001};
            default: tv = {48'h0016_0000_0000, 48'h0019_0000_0000};
        endcase
    endfunction
    function [63:0] mk(input integer n);
        mk = (n == 3 || n == 6) ? 64'hFFFF_FFFF_FFFF_FFFF : 64'hFFFF_FFFF_0000_0000;
    endfunction
    task chk(input [63:0] seen, input [63:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("ERROR %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task run(input [15:0] c, input [15:0] s, input [47:0] d, input [47:0] x,
        input [63:0] msk, input rel);
        begin
            q.push_back({s, x});
            mq.push_back(msk);
            host_i.command(c, d);
            if (rel)
                host_i.release_cmd;
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_mismatch);
            if (n_mismatch == 0 && total_checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    always @(negedge clk) begin
        if (dload === 1'b1)
            nload = nload + 1;
        if (w4 !== last4 && w4 !== 16'h0000) begin
            e = q.pop_front();
            m = mq.pop_front();
            chk({w4, w5, w6, w7} & m, e & m);
        end
        last4 = w4;
    end
    always @(posedge clk) begin
        ticks = ticks + 1;
        if (ticks == 4000) begin
            n_mismatch = n_mismatch + 1;
            end_sim;
        end
    end
    initial begin
        repeat (20) @(negedge clk);
        arst_n = 1'b1;
        for (i = 0; i < 12; i = i + 1) begin
            stat = xs();
            act = xs();
            mant = xs();
            expo = xs();
            a = xs();
            b = xs();
            host_i.levels(a, b);
            chk({w0, w1}, {4'h0, stat[11:0], act & 16'h7D2F});
            chk({w2, w3}, {mant, expo});
            chk({start, lvl}, {a[4:0] & ~p[4:0], a[7:5]});
            chk(areq, b & 16'h7C2F);
            p = a;
        end
        host_i.gap = 3;
        for (k = 2; k < 8; k = k + 1) begin
            v = tv(k);
            a = {8'h82, k[7:0]};
            b = {8'h81, k[7:0]};
            run(a, a, {xs(), xs(), xs()}, v[95:48], mk(k), 1'b1);
            run(b, b, v[47:0], v[47:0], mk(k), 1'b1);
            run(a, a, {xs(), xs(), xs()}, v[47:0], mk(k), 1'b1);
        end
        chk({lock, dlog, lpos}, 3'h5);
        chk({mon, day, year, expv}, 64'h000C_001F_07E8_000A);
        chk({lmant, lexp, gain}, 48'h00C8_0007_0019);
        run(16'h8201, 16'h7F01, {xs(), xs(), xs()}, 48'h0019_0000_0000, mk(7), 1'b1);
        run(16'h8307, 16'h7F03, {xs(), xs(), xs()}, 48'h0019_0000_0000, mk(7), 1'b1);
        run(16'h8202, 16'h8202, {xs(), xs(), xs()}, 48'h0001_0000_0000, mk(2), 1'b0);
        host_i.command(16'h8107, 48'h0055_0000_0000);
        chk({w4, gain}, {16'h8202, 16'h0019});
        host_i.release_cmd;
        chk(w4, 16'h0000);
        chk(q.size(), 0);
        chk(nload, 1);
        end_sim;
    end
endmodule
